// *** src/host_fifo_end.sv ***
// Far end: receive buffer write side and host register master
`timescale 1ns/10ps
module host_fifo_end
  import mac_rx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link to the MAC end
  mac_rx_link_if.host link,
  // User request side
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [REG_W-1:0] cmdWdata,
  input wire logic bufferFull,
  input wire logic dropReq,
  output logic cmdReady,
  output logic rspValid,
  output logic [REG_W-1:0] rspData,
  output logic byteValid,
  output logic [DATA_W-1:0] byteData,
  output logic frameDone,
  output logic frameErr
);
  host_state_e state_reg;
  logic doneSync;

  // Done comes from the MAC clock domain in general, so it is synchronised
  sync_level #(.STAGES(SYNC_STAGES)) doneSyncInst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .asyncIn(!link.regDoneN),
    .syncOut(doneSync)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= HS_IDLE;
      link.regSelectN <= 1'b1;
      link.regWriteN <= 1'b1;
      link.regReadN <= 1'b1;
      link.regAddr <= '0;
      link.regWdata <= '0;
      rspValid <= 1'b0;
      rspData <= '0;
      cmdReady <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          cmdReady <= !cmdValid && !doneSync;
          if (cmdValid && !doneSync) begin
            link.regAddr <= cmdAddr;
            link.regWdata <= cmdWdata;
            link.regSelectN <= 1'b0;
            link.regWriteN <= !cmdWrite;
            link.regReadN <= cmdWrite;
            cmdReady <= 1'b0;
            state_reg <= HS_DONE;
          end
        end
        HS_DONE: begin
          // Address, data and strobes stay still until done
          if (doneSync) begin
            rspData <= link.regRdata;
            rspValid <= 1'b1;
            link.regSelectN <= 1'b1;
            link.regWriteN <= 1'b1;
            link.regReadN <= 1'b1;
            state_reg <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!doneSync) begin
            cmdReady <= 1'b1;
            state_reg <= HS_IDLE;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.bufferFullIn <= 1'b0;
      link.dropPacketsReq <= 1'b0;
      byteValid <= 1'b0;
      byteData <= '0;
      frameDone <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      link.bufferFullIn <= bufferFull;
      link.dropPacketsReq <= dropReq;
      byteValid <= link.bufferWriteReq && !link.bufferFullIn;
      byteData <= link.rxFrameByte;
      frameDone <= link.frameEnd;
      frameErr <= link.frameEnd && (link.frameBad || link.bufferOverrunErr);
    end
  end
endmodule : host_fifo_end

// *** src/mac_rx_end.sv ***
// MAC end: receive FIFO write face and host register port
`timescale 1ns/10ps
module mac_rx_end
  import mac_rx_pkg::*;
#(
  parameter bit MGMT_IFACE_OPTION = 1'b0,
  // Read-back scramble for the scratch register; the value is arbitrary
  parameter logic [REG_W-1:0] DEVICE_TAG = 8'h5A
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link to the FIFO and host side
  mac_rx_link_if.mac link,
  // Received byte stream from the line side
  input wire logic lineValid,
  input wire logic [DATA_W-1:0] lineData,
  input wire logic lineErr,
  // Build option echo and state
  output logic mgmtPresent,
  output logic rxBusy
);
  // One clock serves both sections here; the clock choice per rate is made outside

  function automatic logic hostActive(input logic selN, input logic strobeN, input logic otherN);
    return !selN && !strobeN && otherN;
  endfunction : hostActive

  logic dropSync;
  logic [REG_W-1:0] ctrl_reg;
  logic [REG_W-1:0] scratch_reg;
  logic [REG_W-1:0] frames_reg;
  rx_state_e rxState_reg;
  logic lineValid_reg;
  logic [DATA_W-1:0] lineData_reg;
  logic errSeen_reg;
  logic fullSeen_reg;
  logic [STAT_LEN_W-1:0] len_reg;
  host_state_e hostState_reg;
  logic [REG_W-1:0] rdata_reg;
  logic doneN_reg;
  logic dropNow;
  logic endPend_reg;
  logic endDrop_reg;
  logic frameStart;
  logic frameStop;

  // Drop request arrives from another domain
  sync_level #(.STAGES(SYNC_STAGES)) dropSyncInst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .asyncIn(link.dropPacketsReq),
    .syncOut(dropSync)
  );

  assign dropNow = dropSync || ctrl_reg[CTRL_DROP_BIT];
  assign frameStart = lineValid && !lineValid_reg;
  assign frameStop = !lineValid && lineValid_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mgmtPresent <= 1'b0;
    end else begin
      mgmtPresent <= MGMT_IFACE_OPTION;
    end
  end

  // Line pipeline register delays bytes one cycle so end-of-frame is known in time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lineValid_reg <= 1'b0;
      lineData_reg <= '0;
    end else begin
      lineValid_reg <= lineValid;
      lineData_reg <= lineData;
    end
  end

  // Drop decision is taken only at frame start so a frame is never cut in half
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxState_reg <= RX_IDLE;
    end else begin
      case (rxState_reg)
        RX_IDLE: begin
          if (frameStart) begin
            rxState_reg <= dropNow ? RX_DROP : RX_FRAME;
          end
        end
        RX_FRAME, RX_DROP: begin
          if (frameStop) begin
            rxState_reg <= RX_IDLE;
          end
        end
        default: rxState_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.bufferWriteReq <= 1'b0;
      link.rxFrameByte <= '0;
    end else begin
      link.bufferWriteReq <= (rxState_reg == RX_FRAME) && lineValid_reg;
      link.rxFrameByte <= lineData_reg;
    end
  end

  // Per-frame error, overrun and length tracking; the first byte's error is caught at frame start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      errSeen_reg <= 1'b0;
      fullSeen_reg <= 1'b0;
      len_reg <= '0;
    end else if (rxState_reg == RX_IDLE) begin
      errSeen_reg <= frameStart && lineErr;
      fullSeen_reg <= 1'b0;
      len_reg <= '0;
    end else begin
      if (lineValid && lineErr) begin
        errSeen_reg <= 1'b1;
      end
      if (link.bufferWriteReq && link.bufferFullIn) begin
        fullSeen_reg <= 1'b1;
      end
      if (lineValid_reg) begin
        len_reg <= len_reg + 1'b1;
      end
    end
  end

  // End is reported one cycle after the last byte's write, so no byte is still in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      endPend_reg <= 1'b0;
      endDrop_reg <= 1'b0;
    end else begin
      endPend_reg <= frameStop && rxState_reg != RX_IDLE;
      endDrop_reg <= rxState_reg == RX_DROP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.frameEnd <= 1'b0;
      link.frameBad <= 1'b0;
      link.bufferOverrunErr <= 1'b0;
    end else begin
      link.frameEnd <= endPend_reg && !endDrop_reg;
      link.frameBad <= endPend_reg && !endDrop_reg && errSeen_reg;
      link.bufferOverrunErr <= endPend_reg && !endDrop_reg
        && (fullSeen_reg || (link.bufferWriteReq && link.bufferFullIn));
    end
  end

  // Vector is built and strobed in one cycle at the end of every frame, dropped or kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.statsValid <= 1'b0;
      link.statsVector <= '0;
    end else begin
      link.statsValid <= endPend_reg;
      if (endPend_reg) begin
        link.statsVector <= '0;
        link.statsVector[STAT_LEN_LSB +: STAT_LEN_W] <= len_reg;
        link.statsVector[STAT_BAD_BIT] <= errSeen_reg;
        link.statsVector[STAT_OVR_BIT] <= fullSeen_reg || (link.bufferWriteReq && link.bufferFullIn);
        link.statsVector[STAT_DROP_BIT] <= endDrop_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frames_reg <= REG_RESET;
    end else if (link.frameEnd) begin
      frames_reg <= frames_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxBusy <= 1'b0;
    end else begin
      rxBusy <= rxState_reg != RX_IDLE;
    end
  end

  // Host port: done stays low until the host releases its select
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hostState_reg <= HS_IDLE;
      doneN_reg <= 1'b1;
      rdata_reg <= '0;
      ctrl_reg <= REG_RESET;
      scratch_reg <= REG_RESET;
    end else begin
      case (hostState_reg)
        HS_IDLE: begin
          if (hostActive(link.regSelectN, link.regWriteN, link.regReadN)) begin
            case (link.regAddr)
              REG_CTRL: ctrl_reg <= link.regWdata;
              REG_SCRATCH: scratch_reg <= link.regWdata;
              default: ;
            endcase
            doneN_reg <= 1'b0;
            hostState_reg <= HS_DONE;
          end else if (hostActive(link.regSelectN, link.regReadN, link.regWriteN)) begin
            case (link.regAddr)
              REG_CTRL: rdata_reg <= ctrl_reg;
              REG_STATUS: rdata_reg <= {5'h00, rxBusy, mgmtPresent, dropSync};
              REG_FRAMES: rdata_reg <= frames_reg;
              REG_SCRATCH: rdata_reg <= scratch_reg ^ DEVICE_TAG;
              default: rdata_reg <= REG_RESET;
            endcase
            doneN_reg <= 1'b0;
            hostState_reg <= HS_DONE;
          end
        end
        HS_DONE: begin
          if (link.regSelectN) begin
            doneN_reg <= 1'b1;
            hostState_reg <= HS_IDLE;
          end
        end
        default: begin
          doneN_reg <= 1'b1;
          hostState_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.regDoneN = doneN_reg;
  assign link.regRdata = rdata_reg;
endmodule : mac_rx_end

// *** src/mac_rx_link_if.sv ***
// Interface joining the MAC end and the FIFO/host end
`timescale 1ns/10ps
interface mac_rx_link_if;
  import mac_rx_pkg::*;
  logic [DATA_W-1:0] rxFrameByte;
  logic bufferWriteReq;
  logic bufferFullIn;
  logic frameEnd;
  logic frameBad;
  logic bufferOverrunErr;
  logic [STAT_W-1:0] statsVector;
  logic statsValid;
  logic dropPacketsReq;
  logic regSelectN;
  logic regWriteN;
  logic regReadN;
  logic [ADDR_W-1:0] regAddr;
  logic [REG_W-1:0] regWdata;
  logic [REG_W-1:0] regRdata;
  logic regDoneN;
  modport mac (
    output rxFrameByte, bufferWriteReq, frameEnd, frameBad, bufferOverrunErr, statsVector, statsValid,
    input bufferFullIn, dropPacketsReq,
    input regSelectN, regWriteN, regReadN, regAddr, regWdata,
    output regRdata, regDoneN
  );
  modport host (
    input rxFrameByte, bufferWriteReq, frameEnd, frameBad, bufferOverrunErr, statsVector, statsValid,
    output bufferFullIn, dropPacketsReq,
    output regSelectN, regWriteN, regReadN, regAddr, regWdata,
    input regRdata, regDoneN
  );
endinterface : mac_rx_link_if

// *** src/mac_rx_pkg.sv ***
// Shared constants and types for the receive FIFO face and host register port
package mac_rx_pkg;
  localparam int DATA_W = 8;
  localparam int STAT_W = 32;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int NUM_REGS = 4;
  // Synchroniser depth for inputs from outside the clock domain
  localparam int SYNC_STAGES = 3;
  // Statistics vector field positions
  localparam int STAT_LEN_LSB = 0;
  localparam int STAT_LEN_W = 16;
  localparam int STAT_BAD_BIT = 16;
  localparam int STAT_OVR_BIT = 17;
  localparam int STAT_DROP_BIT = 26;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // Host port register indices, all inside the device's own small register file
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] REG_FRAMES = 8'h02;
  localparam logic [ADDR_W-1:0] REG_SCRATCH = 8'h03;
  // Control bit: force dropping of received frames
  localparam int CTRL_DROP_BIT = 0;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_DONE = 3'b010,
    HS_WAIT = 3'b100
  } host_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_FRAME = 3'b010,
    RX_DROP = 3'b100
  } rx_state_e;
endpackage : mac_rx_pkg

// *** src/sync_level.sv ***
// Three-stage level synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
module sync_level
  import mac_rx_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Level in and filtered level out
  input wire logic asyncIn,
  output logic syncOut
);
  logic [STAGES-1:0] chain_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], asyncIn};
    end
  end

  // First stage feeds only the second; output moves when the last two agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      syncOut <= 1'b0;
    end else if (chain_reg[STAGES-1] == chain_reg[STAGES-2]) begin
      syncOut <= chain_reg[STAGES-1];
    end
  end
endmodule : sync_level

// *** verification/mac_rx_fifo_and_host_port_tb_top.sv ***
// Testbench joining both ends over the link interface
`timescale 1ns/10ps
module mac_rx_fifo_and_host_port_tb_top
  import mac_rx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic lineValid = 1'b0, lineErr = 1'b0, cmdValid = 1'b0, cmdWrite = 1'b0, bufferFull = 1'b0, dropReq = 1'b0;
  logic [DATA_W-1:0] lineData = '0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [REG_W-1:0] cmdWdata = '0;
  logic [REG_W-1:0] rdVal, rspData, byteData;
  logic mgmtPresent, rxBusy, cmdReady, rspValid, byteValid, frameDone, frameErr;
  logic [STAT_W-1:0] lastStat;
  int badCount = 0, numChecks = 0, wrCnt, eofCnt, statCnt, byteErr;
  int byteCnt, doneCnt, errCnt;
  logic lastBad, lastOvr;
  always #12.5 ref_clk = ~ref_clk;
  mac_rx_link_if i_mac_rx_link_if ();
  mac_rx_end #(.MGMT_IFACE_OPTION(1'b1)) i_mac_rx_end (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(i_mac_rx_link_if.mac), .lineValid(lineValid), .lineData(lineData), .lineErr(lineErr),
    .mgmtPresent(mgmtPresent), .rxBusy(rxBusy));
  host_fifo_end i_host_fifo_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i_mac_rx_link_if.host),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .bufferFull(bufferFull),
    .dropReq(dropReq), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .byteValid(byteValid),
    .byteData(byteData), .frameDone(frameDone), .frameErr(frameErr));
  mac_rx_link_checker i_mac_rx_link_checker (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .rxFrameByte(i_mac_rx_link_if.rxFrameByte), .bufferWriteReq(i_mac_rx_link_if.bufferWriteReq),
    .bufferFullIn(i_mac_rx_link_if.bufferFullIn), .frameEnd(i_mac_rx_link_if.frameEnd),
    .frameBad(i_mac_rx_link_if.frameBad), .bufferOverrunErr(i_mac_rx_link_if.bufferOverrunErr),
    .statsVector(i_mac_rx_link_if.statsVector), .statsValid(i_mac_rx_link_if.statsValid),
    .regSelectN(i_mac_rx_link_if.regSelectN), .regWriteN(i_mac_rx_link_if.regWriteN),
    .regReadN(i_mac_rx_link_if.regReadN), .regRdata(i_mac_rx_link_if.regRdata),
    .regDoneN(i_mac_rx_link_if.regDoneN));
  // Wire monitor: bytes must arrive in order, one per write cycle
  always @(posedge ref_clk) begin
    if (!sys_rst) begin
      if (i_mac_rx_link_if.bufferWriteReq) begin
        if (i_mac_rx_link_if.rxFrameByte !== 8'h10 + wrCnt[7:0]) byteErr++;
        wrCnt++;
      end
      if (i_mac_rx_link_if.frameEnd === 1'b1) begin
        eofCnt++;
        lastBad = i_mac_rx_link_if.frameBad;
        lastOvr = i_mac_rx_link_if.bufferOverrunErr;
      end
      if (i_mac_rx_link_if.statsValid === 1'b1) begin
        statCnt++;
        lastStat = i_mac_rx_link_if.statsVector;
      end
      // Far end's buffer side: accepted bytes in order, frame ends and error marks
      if (byteValid === 1'b1) begin
        if (byteData !== 8'h10 + byteCnt[7:0]) byteErr++;
        byteCnt++;
      end
      if (frameDone === 1'b1) doneCnt++;
      if (frameErr === 1'b1) errCnt++;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One register transfer through the far end's request side
  task automatic hostXfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [REG_W-1:0] wd);
    int n;
    @(posedge ref_clk) #1;
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr = addr;
    cmdWdata = wd;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 50);
    #1 cmdValid = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 50);
    rdVal = rspData;
    chk("response", 32'h1, {31'h0, rspValid});
  endtask : hostXfer
  task automatic sendFrame(input int len, input int errAt);
    @(posedge ref_clk) #1;
    wrCnt = 0; eofCnt = 0; statCnt = 0; byteErr = 0; lastStat = '0; lastBad = 1'b0; lastOvr = 1'b0;
    byteCnt = 0; doneCnt = 0; errCnt = 0;
    for (int i = 0; i < len; i++) begin
      lineValid = 1'b1;
      lineData = 8'h10 + i[7:0];
      lineErr = (i == errAt);
      @(posedge ref_clk) #1;
    end
    lineValid = 1'b0;
    lineErr = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : sendFrame
  task automatic chkFrame(input int wr, input int eof, input logic bad, input logic ovr, input logic drop);
    chk("write count", wr, wrCnt);
    chk("byte order", 0, byteErr);
    chk("frame end count", eof, eofCnt);
    chk("bad flag", {31'h0, bad}, {31'h0, lastBad});
    chk("overrun flag", {31'h0, ovr}, {31'h0, lastOvr});
    chk("stats count", 1, statCnt);
    chk("stats bad", {31'h0, bad}, {31'h0, lastStat[STAT_BAD_BIT]});
    chk("stats dropped", {31'h0, drop}, {31'h0, lastStat[STAT_DROP_BIT]});
    chk("fifo bytes", wr, byteCnt);
    chk("fifo frame ends", eof, doneCnt);
    chk("fifo errors", (bad || ovr) ? eof : 0, errCnt);
  endtask : chkFrame
  task automatic testDone();
    $display("Checks made %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : testDone
  initial begin
    #100us;
    badCount++;
    testDone();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("mgmt option", 1, {31'h0, mgmtPresent});
    hostXfer(1'b1, REG_SCRATCH, 8'hA3);
    hostXfer(1'b0, REG_SCRATCH, 8'h00);
    chk("scratch", 8'hF9, rdVal);
    $display("Test registers done");
    sendFrame(5, -1);
    chkFrame(5, 1, 1'b0, 1'b0, 1'b0);
    chk("stats length", 5, lastStat[STAT_LEN_W-1:0]);
    sendFrame(4, 2);
    chkFrame(4, 1, 1'b1, 1'b0, 1'b0);
    $display("Test frames done");
    #1 bufferFull = 1'b1;
    sendFrame(3, -1);
    bufferFull = 1'b0;
    chk("overrun", 1, {31'h0, lastOvr});
    chk("stats overrun", 1, {31'h0, lastStat[STAT_OVR_BIT]});
    chk("fifo bytes lost", 0, byteCnt);
    chk("fifo overrun error", 1, errCnt);
    $display("Test overrun done");
    dropReq = 1'b1;
    repeat (10) @(posedge ref_clk);
    hostXfer(1'b0, REG_STATUS, 8'h00);
    chk("status", 3'h3, rdVal[2:0]);
    sendFrame(4, -1);
    chkFrame(0, 0, 1'b0, 1'b0, 1'b1);
    #1 dropReq = 1'b0;
    repeat (10) @(posedge ref_clk);
    hostXfer(1'b1, REG_CTRL, 8'h01);
    hostXfer(1'b0, REG_CTRL, 8'h00);
    chk("ctrl", 1, rdVal);
    sendFrame(4, -1);
    chkFrame(0, 0, 1'b0, 1'b0, 1'b1);
    hostXfer(1'b1, REG_CTRL, 8'h00);
    sendFrame(2, -1);
    chkFrame(2, 1, 1'b0, 1'b0, 1'b0);
    hostXfer(1'b0, REG_FRAMES, 8'h00);
    chk("frame counter", 4, rdVal);
    $display("Test drop done");
    testDone();
  end
endmodule : mac_rx_fifo_and_host_port_tb_top

// *** verification/mac_rx_link_checker.sv ***
// Assertions on the link between the MAC end and the FIFO/host end
`timescale 1ns/10ps
module mac_rx_link_checker
  import mac_rx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Receive FIFO face
  input wire logic [DATA_W-1:0] rxFrameByte,
  input wire logic bufferWriteReq,
  input wire logic bufferFullIn,
  input wire logic frameEnd,
  input wire logic frameBad,
  input wire logic bufferOverrunErr,
  input wire logic [STAT_W-1:0] statsVector,
  input wire logic statsValid,
  // Host port
  input wire logic regSelectN,
  input wire logic regWriteN,
  input wire logic regReadN,
  input wire logic [REG_W-1:0] regRdata,
  input wire logic regDoneN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Helper state, cleared on frame end so each frame is judged alone
  logic ovrSeen_reg;
  logic [STAT_LEN_W-1:0] wrCount_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameEnd) begin
      ovrSeen_reg <= 1'b0;
    end else if (bufferWriteReq && bufferFullIn) begin
      ovrSeen_reg <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameEnd) begin
      wrCount_reg <= '0;
    end else if (bufferWriteReq) begin
      wrCount_reg <= wrCount_reg + 1'b1;
    end
  end
  AST_BAD_QUALIFIED: assert property (frameBad |-> frameEnd)
    else $error("bad flag without frame end");
  AST_OVR_QUALIFIED: assert property (bufferOverrunErr |-> frameEnd)
    else $error("overrun flag without frame end");
  AST_OVR_CAUSE: assert property (frameEnd |->
    bufferOverrunErr == (ovrSeen_reg || (bufferWriteReq && bufferFullIn)))
    else $error("overrun flag does not match buffer full during writes");
  AST_WRITE_HELD: assert property ($fell(bufferWriteReq) |-> frameEnd)
    else $error("write request dropped before frame end");
  AST_EOF_PULSE: assert property (frameEnd |=> !frameEnd && !bufferWriteReq)
    else $error("frame end longer than one cycle");
  AST_STATS_WITH_EOF: assert property (frameEnd |-> statsValid && statsVector[STAT_LEN_W-1:0] == wrCount_reg)
    else $error("statistics missing or length wrong at frame end");
  AST_DONE_ANSWER: assert property ($fell(regSelectN) && (regWriteN != regReadN) |=> !regDoneN)
    else $error("done not given one cycle after request");
  AST_DONE_HOLDS: assert property (!regDoneN && !regSelectN |=> !regDoneN)
    else $error("done released while selected");
  AST_DONE_RELEASE: assert property (regSelectN && $past(regSelectN) |-> regDoneN)
    else $error("done low without select");
  AST_RDATA_STABLE: assert property (!regDoneN && $past(!regDoneN) |-> $stable(regRdata))
    else $error("read data moved while done low");
  cover property (frameEnd && frameBad);
  cover property (frameEnd && bufferOverrunErr);
  cover property (statsValid && statsVector[STAT_DROP_BIT]);
  cover property (!regDoneN && regWriteN);
endmodule : mac_rx_link_checker
